// [inc/lcd_dual_pkg.sv]
package lcd_dual_pkg;
   // Register byte offsets
   localparam logic [7:0] CTRL_OFFSET = 8'h00;
   localparam logic [7:0] STATUS_OFFSET = 8'h04;
   localparam logic [7:0] FRAME_DIV_OFFSET = 8'h08;
   localparam logic [7:0] BLINK_DIV_OFFSET = 8'h0C;
   localparam logic [7:0] PRIMARY_BASE = 8'h40;
   localparam logic [7:0] BLINK_BASE = 8'h80;
   // Control field positions
   localparam int SELECT_BIT = 0;
   localparam int MODE_LSB = 1;
   localparam int CLEAR_PRIMARY_BIT = 3;
   localparam int CLEAR_BLINK_BIT = 4;
   // Status field positions
   localparam int SHOWN_BIT = 0;
   // Reset values
   localparam logic [31:0] FRAME_DIV_RESET = 32'h0000_0FFF;
   localparam logic [31:0] BLINK_DIV_RESET = 32'h0000_001F;
   // Blink mode codes
   localparam logic [1:0] MODE_NONE = 2'h0;
   localparam logic [1:0] MODE_ALTERNATE = 2'h3;
   // Bus responses
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
   // Segment memory geometry
   localparam int MEM_WORDS = 8;
endpackage : lcd_dual_pkg

// [design/frame_timer.sv]
`timescale 1ns/1ps
// Frame and blink tick generator. The frame divider is compared every cycle, the blink divider on frame ticks, so a change acts at its next compare.
module frame_timer (
   input wire logic clock_in,
   input wire logic rst_in,
   input wire logic enable_in,
   input wire logic [31:0] frame_div_in,
   input wire logic [31:0] blink_div_in,
   output logic frame_tick_out,
   output logic blink_tick_out
);
   logic [31:0] frame_count;
   logic [31:0] blink_count;

   // Frame counter; a divider of 0 gives a tick every cycle
   always_ff @(posedge clock_in) begin
      if (rst_in) begin
         frame_count <= 32'h0000_0000;
         frame_tick_out <= 1'b0;
      end else if (enable_in) begin
         frame_tick_out <= (frame_count >= frame_div_in);
         if (frame_count >= frame_div_in) begin
            frame_count <= 32'h0000_0000;
         end else begin
            frame_count <= frame_count + 32'h0000_0001;
         end
      end
   end

   // Blink counter counts frames, so blink edges land on frame boundaries
   always_ff @(posedge clock_in) begin
      if (rst_in) begin
         blink_count <= 32'h0000_0000;
         blink_tick_out <= 1'b0;
      end else if (enable_in) begin
         blink_tick_out <= 1'b0;
         if (frame_count >= frame_div_in) begin
            if (blink_count >= blink_div_in) begin
               blink_count <= 32'h0000_0000;
               blink_tick_out <= 1'b1;
            end else begin
               blink_count <= blink_count + 32'h0000_0001;
            end
         end
      end
   end
endmodule : frame_timer

// [design/lcd_dual_display_memory.sv]
// Decided for this implementation: the AXI4-Lite interface to the registers and the placing of the registers.
`timescale 1ns/1ps
module lcd_dual_display_memory #(
   parameter int SEG_WIDTH = 32
) (
   input wire logic clock_in,
   input wire logic rst_in,
   input wire logic enable_in,
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   output logic [lcd_dual_pkg::MEM_WORDS*SEG_WIDTH-1:0] segments_out,
   output logic frame_tick_out
);
   import lcd_dual_pkg::*;

   logic [SEG_WIDTH-1:0] primary_mem [MEM_WORDS];
   logic [SEG_WIDTH-1:0] blink_mem [MEM_WORDS];
   logic display_memory_select;
   logic [1:0] blink_mode_field;
   logic clear_display_memory;
   logic clear_blink_memory;
   logic [31:0] frame_div;
   logic [31:0] blink_div;
   logic shown_blink;
   logic alt_phase;
   logic blink_tick;
   logic aw_held;
   logic w_held;
   logic [7:0] aw_addr;
   logic [31:0] w_data;
   logic [3:0] w_strb;
   logic do_write;
   logic wr_ok;
   logic next_source;

   // Memory word index of an address in a given window, or out of range
   function automatic logic in_window(input logic [7:0] addr, input logic [7:0] base);
      in_window = (addr >= base) && (addr < base + 8'(4 * MEM_WORDS)) && (addr[1:0] == 2'h0);
   endfunction : in_window

   function automatic logic [2:0] word_index(input logic [7:0] addr, input logic [7:0] base);
      logic [7:0] diff;
      diff = addr - base;
      word_index = diff[4:2];
   endfunction : word_index

   // Byte-lane merge used by the divider registers and segment memories; control takes byte 0 only
   function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] data,
                                         input logic [3:0] strb);
      logic [31:0] res;
      res = old;
      for (int b = 0; b < 4; b++) begin
         if (strb[b]) begin
            res[8*b +: 8] = data[8*b +: 8];
         end
      end
      merge = res;
   endfunction : merge

   frame_timer u_timer (
      .clock_in(clock_in),
      .rst_in(rst_in),
      .enable_in(enable_in),
      .frame_div_in(frame_div),
      .blink_div_in(blink_div),
      .frame_tick_out(frame_tick_out),
      .blink_tick_out(blink_tick)
   );

   // Write channel capture; address and data may come in either order
   assign s_axi_awready = !aw_held && !s_axi_bvalid;
   assign s_axi_wready = !w_held && !s_axi_bvalid;
   assign do_write = aw_held && w_held && !s_axi_bvalid;
   assign wr_ok = (aw_addr == CTRL_OFFSET) || (aw_addr == FRAME_DIV_OFFSET)
      || (aw_addr == BLINK_DIV_OFFSET) || in_window(aw_addr, PRIMARY_BASE)
      || in_window(aw_addr, BLINK_BASE);

   always_ff @(posedge clock_in) begin
      if (rst_in) begin
         aw_held <= 1'b0;
         w_held <= 1'b0;
         aw_addr <= 8'h00;
         w_data <= 32'h0000_0000;
         w_strb <= 4'h0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= RESP_OKAY;
      end else if (enable_in) begin
         if (s_axi_awvalid && s_axi_awready) begin
            aw_held <= 1'b1;
            aw_addr <= s_axi_awaddr;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_held <= 1'b1;
            w_data <= s_axi_wdata;
            w_strb <= s_axi_wstrb;
         end
         if (do_write) begin
            aw_held <= 1'b0;
            w_held <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= wr_ok ? RESP_OKAY : RESP_SLVERR;
         end else if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
      end
   end

   // Control register; self-clearing bits drop after the frame-boundary wipe.
   // A software set in the same cycle as the wipe wins, so a new request is kept.
   always_ff @(posedge clock_in) begin
      if (rst_in) begin
         display_memory_select <= 1'b0;
         blink_mode_field <= MODE_NONE;
         clear_display_memory <= 1'b0;
         clear_blink_memory <= 1'b0;
         frame_div <= FRAME_DIV_RESET;
         blink_div <= BLINK_DIV_RESET;
      end else if (enable_in) begin
         if (frame_tick_out) begin
            clear_display_memory <= 1'b0;
            clear_blink_memory <= 1'b0;
         end
         if (do_write && aw_addr == CTRL_OFFSET && w_strb[0]) begin
            display_memory_select <= w_data[SELECT_BIT];
            blink_mode_field <= w_data[MODE_LSB +: 2];
            if (w_data[CLEAR_PRIMARY_BIT]) clear_display_memory <= 1'b1;
            if (w_data[CLEAR_BLINK_BIT]) clear_blink_memory <= 1'b1;
         end
         if (do_write && aw_addr == FRAME_DIV_OFFSET) begin
            frame_div <= merge(frame_div, w_data, w_strb);
         end
         if (do_write && aw_addr == BLINK_DIV_OFFSET) begin
            blink_div <= merge(blink_div, w_data, w_strb);
         end
      end
   end

   // Segment memories; clears happen on the frame tick, after software writes
   always_ff @(posedge clock_in) begin
      if (rst_in) begin
         for (int i = 0; i < MEM_WORDS; i++) begin
            primary_mem[i] <= '0;
            blink_mem[i] <= '0;
         end
      end else if (enable_in) begin
         if (do_write && in_window(aw_addr, PRIMARY_BASE)) begin
            primary_mem[word_index(aw_addr, PRIMARY_BASE)] <= SEG_WIDTH'(merge(
               32'(primary_mem[word_index(aw_addr, PRIMARY_BASE)]), w_data, w_strb));
         end
         if (do_write && in_window(aw_addr, BLINK_BASE)) begin
            blink_mem[word_index(aw_addr, BLINK_BASE)] <= SEG_WIDTH'(merge(
               32'(blink_mem[word_index(aw_addr, BLINK_BASE)]), w_data, w_strb));
         end
         for (int i = 0; i < MEM_WORDS; i++) begin
            if (frame_tick_out && clear_display_memory) primary_mem[i] <= '0;
            if (frame_tick_out && clear_blink_memory) blink_mem[i] <= '0;
         end
      end
   end

   // Source choice: alternate phase in mode 3, else the select bit (modes 1 and 2 act as 0)
   assign next_source = (blink_mode_field == MODE_ALTERNATE) ? alt_phase
      : display_memory_select;

   // Alternation phase advances on blink ticks, which sit on frame ticks
   always_ff @(posedge clock_in) begin
      if (rst_in) begin
         alt_phase <= 1'b0;
      end else if (enable_in) begin
         if (blink_mode_field != MODE_ALTERNATE) begin
            alt_phase <= 1'b0;
         end else if (blink_tick) begin
            alt_phase <= !alt_phase;
         end
      end
   end

   // Shown source latches only at frame boundaries to keep frames whole
   always_ff @(posedge clock_in) begin
      if (rst_in) begin
         shown_blink <= 1'b0;
      end else if (enable_in && frame_tick_out) begin
         shown_blink <= next_source;
      end
   end

   // Segment outputs: one registered mux, so every segment swaps together
   always_ff @(posedge clock_in) begin
      if (rst_in) begin
         segments_out <= '0;
      end else if (enable_in) begin
         for (int i = 0; i < MEM_WORDS; i++) begin
            segments_out[i*SEG_WIDTH +: SEG_WIDTH] <=
               shown_blink ? blink_mem[i] : primary_mem[i];
         end
      end
   end

   // Read channel; one read at a time, answered one cycle after address
   assign s_axi_arready = !s_axi_rvalid;
   always_ff @(posedge clock_in) begin
      if (rst_in) begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h0000_0000;
         s_axi_rresp <= RESP_OKAY;
      end else if (enable_in) begin
         if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp <= RESP_OKAY;
            if (s_axi_araddr == CTRL_OFFSET) begin
               s_axi_rdata <= 32'({clear_blink_memory, clear_display_memory,
                                   blink_mode_field, display_memory_select});
            end else if (s_axi_araddr == STATUS_OFFSET) begin
               s_axi_rdata <= 32'(shown_blink);
            end else if (s_axi_araddr == FRAME_DIV_OFFSET) begin
               s_axi_rdata <= frame_div;
            end else if (s_axi_araddr == BLINK_DIV_OFFSET) begin
               s_axi_rdata <= blink_div;
            end else if (in_window(s_axi_araddr, PRIMARY_BASE)) begin
               s_axi_rdata <= 32'(primary_mem[word_index(s_axi_araddr, PRIMARY_BASE)]);
            end else if (in_window(s_axi_araddr, BLINK_BASE)) begin
               s_axi_rdata <= 32'(blink_mem[word_index(s_axi_araddr, BLINK_BASE)]);
            end else begin
               s_axi_rdata <= 32'h0000_0000;
               s_axi_rresp <= RESP_SLVERR;
            end
         end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
         end
      end
   end

   // Source changes only on a frame tick
   property p_source_at_frame;
      @(posedge clock_in) disable iff (rst_in)
      !$past(frame_tick_out) && $past(enable_in) |-> $stable(shown_blink);
   endproperty
   a_source_at_frame: assert property (p_source_at_frame) else $error("source moved off frame");
   // Outputs follow the blink memory one cycle later while it is shown; the update needs only one enabled edge
   property p_outputs_follow;
      @(posedge clock_in) disable iff (rst_in)
      enable_in && shown_blink |=> segments_out[SEG_WIDTH-1:0] == $past(blink_mem[0]);
   endproperty
   a_outputs_follow: assert property (p_outputs_follow) else $error("segments not blink mem");
   // Clear bit drops after a frame tick
   property p_clear_done;
      @(posedge clock_in) disable iff (rst_in)
      enable_in && frame_tick_out && clear_display_memory && !do_write
      |=> !clear_display_memory && primary_mem[0] == '0;
   endproperty
   a_clear_done: assert property (p_clear_done) else $error("primary clear not done");
   property p_blink_clear_done;
      @(posedge clock_in) disable iff (rst_in)
      enable_in && frame_tick_out && clear_blink_memory && !do_write
      |=> !clear_blink_memory && blink_mem[0] == '0;
   endproperty
   a_blink_clear_done: assert property (p_blink_clear_done) else $error("blink clear not done");
   // Outside alternation the shown source follows the select bit at a frame tick
   property p_select;
      @(posedge clock_in) disable iff (rst_in)
      enable_in && frame_tick_out && blink_mode_field != MODE_ALTERNATE
      |=> shown_blink == $past(display_memory_select);
   endproperty
   a_select: assert property (p_select) else $error("select not applied");
   // In mode 3 a blink tick flips the phase
   property p_alternate;
      @(posedge clock_in) disable iff (rst_in)
      enable_in && blink_tick && blink_mode_field == MODE_ALTERNATE && $stable(blink_mode_field)
      |=> alt_phase != $past(alt_phase);
   endproperty
   a_alternate: assert property (p_alternate) else $error("phase did not flip");
endmodule : lcd_dual_display_memory

// [bench/lcd_glass_model.sv]
`timescale 1ns/1ps
// Glass model: the panel latches a whole image per frame, so any segment
// change that does not follow a frame tick would show as a torn frame.
module lcd_glass_model #(
   parameter int W = 256
) (
   input wire logic clock_in,
   input wire logic rst_in,
   input wire logic [W-1:0] segments_in,
   input wire logic frame_tick_in,
   output int tear_count
);
   logic [W-1:0] last_image;
   logic [1:0] tick_hist;
   // Count image changes outside the two cycles after a frame boundary; one driver only
   always @(posedge clock_in) begin
      if (rst_in) begin
         tear_count <= 0;
      end else if (segments_in !== last_image && tick_hist == 2'b00) begin
         tear_count <= tear_count + 1;
      end
      last_image <= segments_in;
      tick_hist <= {tick_hist[0], frame_tick_in};
   end
endmodule : lcd_glass_model

// [bench/lcd_dual_display_memory_tb_top.sv]
`timescale 1ns/1ps
module lcd_dual_display_memory_tb_top;
   import lcd_dual_pkg::*;
   logic clock_in = 0, rst_in = 1, enable_in = 1;
   logic [7:0] s_axi_awaddr = 0, s_axi_araddr = 0;
   logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
   logic s_axi_arvalid = 0, s_axi_rready = 0;
   logic [31:0] s_axi_wdata = 0;
   logic [3:0] s_axi_wstrb = 4'hF;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic [1:0] s_axi_bresp, s_axi_rresp;
   logic [31:0] s_axi_rdata;
   logic [255:0] segments_out, prim_img, blk_img, prev;
   logic frame_tick_out;
   logic [31:0] d;
   logic [1:0] r;
   int tear_count, mismatches = 0, check_count = 0, changes;
   lcd_dual_display_memory #(.SEG_WIDTH(32)) uut (.clock_in(clock_in), .rst_in(rst_in),
      .enable_in(enable_in), .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
      .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
      .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
      .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
      .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
      .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
      .s_axi_rready(s_axi_rready), .segments_out(segments_out),
      .frame_tick_out(frame_tick_out));
   lcd_glass_model #(.W(256)) glass (.clock_in(clock_in), .rst_in(rst_in),
      .segments_in(segments_out), .frame_tick_in(frame_tick_out), .tear_count(tear_count));
   // 125 MHz clock
   initial begin
      forever #4 clock_in = ~clock_in;
   end
   task automatic check(input logic [255:0] seen, input logic [255:0] exp);
      check_count++;
      if (seen !== exp) begin
         mismatches++;
         $display("FAIL t=%0t seen %h exp %h", $time, seen, exp);
      end
   endtask : check
   // Write: address and data offered together, each released when taken
   task automatic axi_write(input logic [7:0] a, input logic [31:0] v);
      @(posedge clock_in);
      s_axi_awaddr <= a;
      s_axi_wdata <= v;
      s_axi_awvalid <= 1;
      s_axi_wvalid <= 1;
      s_axi_bready <= 1;
      do begin
         @(posedge clock_in);
         if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 0;
         if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 0;
      end while (s_axi_bvalid !== 1'b1);
      s_axi_bready <= 0;
      r = s_axi_bresp;
   endtask : axi_write
   task automatic axi_read(input logic [7:0] a);
      @(posedge clock_in);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1;
      s_axi_rready <= 1;
      do begin
         @(posedge clock_in);
         if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 0;
      end while (s_axi_rvalid !== 1'b1);
      s_axi_rready <= 0;
      d = s_axi_rdata;
      r = s_axi_rresp;
   endtask : axi_read
   // Source is latched at the tick and lands a cycle later, so settle past it
   task automatic wait_frame();
      do @(posedge clock_in); while (frame_tick_out !== 1'b1);
      repeat (2) @(posedge clock_in);
      #1;
   endtask : wait_frame
   // Poll a self-clearing bit with a bounded number of reads
   task automatic wait_bit_low(input int b);
      int n;
      n = 0;
      do begin
         axi_read(CTRL_OFFSET);
         n++;
      end while (d[b] !== 1'b0 && n < 50);
   endtask : wait_bit_low
   task automatic print_verdict();
      $display("checks %0d mismatches %0d", check_count, mismatches);
      if (mismatches == 0 && check_count > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask : print_verdict
   // Whole run needs a few hundred cycles
   initial begin
      repeat (20000) @(posedge clock_in);
      mismatches++;
      print_verdict();
   end
   initial begin
      for (int i = 0; i < 8; i++) begin
         prim_img[i*32+:32] = 32'hA5C3_0000 + 32'(i);
         blk_img[i*32+:32] = 32'h3C5A_0100 + 32'(i);
      end
      repeat (10) @(posedge clock_in);
      rst_in <= 0;
      axi_read(CTRL_OFFSET);
      check(256'(d), 256'h0);
      axi_read(FRAME_DIV_OFFSET);
      check(256'(d), 256'(FRAME_DIV_RESET));
      axi_read(BLINK_DIV_OFFSET);
      check(256'(d), 256'(BLINK_DIV_RESET));
      axi_read(8'hF0);
      check(256'({r, d}), 256'({RESP_SLVERR, 32'h0}));
      axi_write(8'hF4, 32'h1);
      check(256'(r), 256'(RESP_SLVERR));
      // Short dividers keep frames at 4 cycles and blink at 2 frames
      axi_write(FRAME_DIV_OFFSET, 32'h3);
      axi_write(BLINK_DIV_OFFSET, 32'h1);
      $display("test registers done");
      axi_write(CTRL_OFFSET, 32'h1);
      wait_frame();
      check(segments_out, 256'h0);
      axi_read(STATUS_OFFSET);
      check(256'(d[SHOWN_BIT]), 256'h1);
      for (int i = 0; i < 8; i++) axi_write(PRIMARY_BASE + 8'(4 * i), prim_img[i*32+:32]);
      check(segments_out, 256'h0);
      axi_write(CTRL_OFFSET, 32'h0);
      wait_frame();
      check(segments_out, prim_img);
      for (int i = 0; i < 8; i++) axi_write(BLINK_BASE + 8'(4 * i), blk_img[i*32+:32]);
      wait_frame();
      check(segments_out, prim_img);
      axi_write(CTRL_OFFSET, 32'h1);
      wait_frame();
      check(segments_out, blk_img);
      $display("test double buffer done");
      axi_write(CTRL_OFFSET, 32'h6);
      wait_frame();
      changes = 0;
      for (int k = 0; k < 8; k++) begin
         prev = segments_out;
         wait_frame();
         if (segments_out !== prev) changes++;
         check(256'(segments_out === prim_img || segments_out === blk_img), 256'h1);
      end
      check(256'(changes), 256'h4);
      // Clock enable low freezes alternation; twelve cycles would hold at least one swap
      @(posedge clock_in);
      enable_in <= 0;
      repeat (2) @(posedge clock_in);
      prev = segments_out;
      repeat (12) @(posedge clock_in);
      check(segments_out, prev);
      enable_in <= 1;
      axi_write(CTRL_OFFSET, 32'h0);
      wait_frame();
      check(segments_out, prim_img);
      $display("test alternate done");
      axi_write(CTRL_OFFSET, 32'h10);
      wait_bit_low(CLEAR_BLINK_BIT);
      check(256'(d[CLEAR_BLINK_BIT]), 256'h0);
      axi_read(BLINK_BASE + 8'h1C);
      check(256'(d), 256'h0);
      check(segments_out, prim_img);
      axi_write(CTRL_OFFSET, 32'h8);
      wait_bit_low(CLEAR_PRIMARY_BIT);
      check(256'(d[CLEAR_PRIMARY_BIT]), 256'h0);
      wait_frame();
      check(segments_out, 256'h0);
      // Frame divider 3 gives a tick every fourth cycle
      @(posedge clock_in);
      check(256'(frame_tick_out), 256'h0);
      @(posedge clock_in);
      check(256'(frame_tick_out), 256'h1);
      check(256'(tear_count), 256'h0);
      $display("test clear done");
      print_verdict();
   end
endmodule : lcd_dual_display_memory_tb_top
